// *** rtl/bsm_pkg.sv ***
package bsm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Operand size field codes
   localparam logic [1:0] SZ_BYTE  = 2'h0;
   localparam logic [1:0] SZ_RSVD  = 2'h1;
   localparam logic [1:0] SZ_WORD  = 2'h2;
   localparam logic [1:0] SZ_DWORD = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Operations, one-hot
   typedef enum logic [5:0] {
      OP_JNB = 6'h01,
      OP_JNZ = 6'h02,
      OP_JZ  = 6'h04,
      OP_LEA = 6'h08,
      OP_LSR = 6'h10,
      OP_MOV = 6'h20
   } bsm_op_t;

   // Data move addressing forms
   localparam logic [2:0] MV_RR   = 3'h0;
   localparam logic [2:0] MV_RIND = 3'h1;
   localparam logic [2:0] MV_WIND = 3'h2;
   localparam logic [2:0] MV_ROFF = 3'h3;
   localparam logic [2:0] MV_WOFF = 3'h4;
   localparam logic [2:0] MV_RINC = 3'h5;
   localparam logic [2:0] MV_WINC = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // Clock costs
   localparam int         CNT_W       = 5;
   localparam int         CNT_MAX     = 31;
   localparam logic [4:0] CYC_ONE     = 5'h1;
   localparam logic [4:0] CYC_BIT_T   = 5'hA;
   localparam logic [4:0] CYC_BIT_NT  = 5'h6;
   localparam logic [4:0] CYC_ACC_T   = 5'h6;
   localparam logic [4:0] CYC_ACC_NT  = 5'h3;
   localparam logic [4:0] CYC_LEA     = 5'h3;
   localparam logic [4:0] CYC_SH16    = 5'h4;
   localparam logic [4:0] CYC_SH32    = 5'h6;
   localparam logic [4:0] CYC_MOV     = 5'h3;
   localparam logic [4:0] CYC_MOV_INC = 5'h4;
   localparam logic [4:0] CYC_MOV_OFF = 5'h5;

   // Instruction lengths and pointer steps
   localparam logic [15:0] LEN_BIT     = 16'h4;
   localparam logic [15:0] LEN_ACC     = 16'h2;
   localparam logic [15:0] LEN_LEA8    = 16'h3;
   localparam logic [15:0] LEN_LEA16   = 16'h4;
   localparam logic [15:0] LEN_LSR     = 16'h2;
   localparam logic [15:0] LEN_MOV     = 16'h2;
   localparam logic [15:0] LEN_MOV_OFF = 16'h3;
   localparam logic [15:0] INC_BYTE    = 16'h1;
   localparam logic [15:0] INC_WORD    = 16'h2;

   ////////////////////////////////////////////////////////////////////////
   // Register port map; addresses below A_PC reach R0..R7
   localparam int         A_HI    = 3;
   localparam logic [3:0] A_PC    = 4'h8;
   localparam logic [3:0] A_ACC   = 4'h9;
   localparam logic [3:0] A_FLAGS = 4'hA;
   localparam logic [3:0] A_STAT  = 4'hB;
   localparam logic [3:0] A_MEMP  = 4'hC;
   localparam logic [3:0] A_MEMD  = 4'hD;
   localparam int         FL_C    = 0;
   localparam int         FL_Z    = 1;
   localparam int         FL_N    = 2;
   localparam int         ST_BUSY = 0;
   localparam int         ST_ERR  = 1;

   localparam int MEM_AW    = 6;
   localparam int MEM_DEPTH = 64;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } bsm_bus_t;

   typedef struct packed {
      bsm_op_t     op;
      logic [1:0]  size;
      logic [2:0]  mode;
      logic [2:0]  rd;
      logic [2:0]  rs;
      logic        cnt_imm;
      logic        off16;
      logic [3:0]  bit_sel;
      logic [15:0] imm;
   } bsm_cmd_t;

endpackage

// *** rtl/bsm_exec.sv ***
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Bit-clear jump adds 4 to PC; if bit zero, PC+2*disp, bit0 cleared.
// - Short branches reach +254/-256 bytes; targets are always word aligned.
// - Accumulator branches are two bytes, 6 clocks taken, 3 not taken.
// - Branch-if-nonzero adds 2 to PC, branches when accumulator nonzero.
// - Branch-if-zero branches only when accumulator is zero, else falls through.
// - Accumulator branches change neither accumulator nor any flag.
// - Effective address writes source plus 8/16-bit offset; no flags touched.
// - Effective address result is always a full word.
// - Logical right shift moves destination right, zeros enter at top.
// - Each bit leaving the bottom passes through carry; carry keeps last.
// - Zero shift count leaves destination unchanged.
// - Shift count runs 0 to 31; count operand never altered.
// - 32-bit shifts use an even-aligned register pair; sizes 8/16/32.
// - Register count uses low five bits; immediate count also uses only its low five bits.
// - Shift updates Z, and C and N unless count is zero; N then cleared.
// - Shift costs 4 or 6 clocks plus one per two bits shifted.
// - Size field: 00 byte, 10 word, 11 double word, 01 reserved.
// - Data move copies byte or word; source is left unchanged.
// - Post-increment only with plain indirect, never with offset.
// - Post-increment adds 1 for byte, 2 for word transfers.
// - Offset move addresses pointer plus 8-bit offset; takes 5 clocks.
module bsm_exec
   import bsm_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire bsm_bus_t bus,
   output logic [15:0]   rdata,
   input  wire logic     cmd_valid,
   input  wire bsm_cmd_t cmd,
   output logic          cmd_ready,
   output logic          done,
   output logic          fault
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_EXEC = 2'h2
   } bsm_fsm_t;

   typedef struct packed {
      bsm_fsm_t                    fsm;
      logic [CNT_W-1:0]            cnt;
      logic [15:0]                 pc;
      logic [7:0][15:0]            r;
      logic [7:0]                  acc;
      logic                        c;
      logic                        z;
      logic                        n;
      logic                        err;
      logic [MEM_AW-1:0]           mp;
      logic [MEM_DEPTH-1:0][7:0]   mem;
      logic [15:0]                 rdata;
      logic                        done;
   } bsm_st_t;

   bsm_st_t q;
   bsm_st_t next_q;

   ////////////////////////////////////////////////////////////////////////
   // Relative target; only the low byte of d is the displacement
   function automatic logic [15:0] br_f(input logic [15:0] p,
                                        input logic [15:0] d);
      logic [15:0] t;
      t = p + {{7{d[7]}}, d[7:0], 1'b0};
      t[0] = 1'b0;
      return t;
   endfunction

   // Operand arrives zero-extended, so zeros reach the field's top bit
   function automatic logic [32:0] lsr_f(input logic [31:0]      v,
                                         input logic [CNT_W-1:0] k,
                                         input logic             cin);
      logic [31:0] x;
      logic        c;
      x = v;
      c = cin;
      for (int i = 0; i < CNT_MAX; i++) begin
         if (i < int'(k)) begin
            c = x[0];
            x = {1'b0, x[31:1]};
         end
      end
      return {c, x};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [15:0]      pn;
      logic [15:0]      v;
      logic [15:0]      ptr;
      logic [15:0]      ea;
      logic [15:0]      off;
      logic [31:0]      opnd;
      logic [32:0]      sh;
      logic [CNT_W-1:0] k;
      logic [4:0]       cyc;
      logic [2:0]       rl;
      logic [2:0]       rh;
      logic [2:0]       pi;
      logic [MEM_AW-1:0] a;
      logic [MEM_AW-1:0] a1;
      logic             tk;
      logic             wd;
      logic             rdm;
      logic             wrm;
      logic             inc;
      logic             offm;
      pn   = q.pc;
      v    = '0;
      ptr  = '0;
      ea   = '0;
      off  = '0;
      opnd = '0;
      sh   = '0;
      k    = '0;
      cyc  = CYC_ONE;
      rl   = {cmd.rd[2:1], 1'b0};
      rh   = {cmd.rd[2:1], 1'b1};
      pi   = '0;
      a    = '0;
      a1   = '0;
      tk   = 1'b0;
      wd   = (cmd.size == SZ_WORD);
      rdm  = 1'b0;
      wrm  = 1'b0;
      inc  = 1'b0;
      offm = 1'b0;
      next_q       = q;
      next_q.done  = 1'b0;
      next_q.rdata = '0;

      ////////////////////////////////////////////////////////////////////
      // Register port; an instruction issued in the same cycle wins
      if (bus.wr) begin
         if (!bus.addr[A_HI]) begin
            next_q.r[bus.addr[2:0]] = bus.wdata;
         end else begin
            case (bus.addr)
               A_PC:    next_q.pc = bus.wdata;
               A_ACC:   next_q.acc = bus.wdata[7:0];
               A_FLAGS: begin
                  next_q.c = bus.wdata[FL_C];
                  next_q.z = bus.wdata[FL_Z];
                  next_q.n = bus.wdata[FL_N];
               end
               A_STAT:  if (bus.wdata[ST_ERR]) next_q.err = 1'b0;
               A_MEMP:  next_q.mp = bus.wdata[MEM_AW-1:0];
               A_MEMD:  next_q.mem[q.mp] = bus.wdata[7:0];
               default: ;
            endcase
         end
      end
      if (bus.rd) begin
         if (!bus.addr[A_HI]) begin
            next_q.rdata = q.r[bus.addr[2:0]];
         end else begin
            case (bus.addr)
               A_PC:    next_q.rdata = q.pc;
               A_ACC:   next_q.rdata = {8'h00, q.acc};
               A_FLAGS: begin
                  next_q.rdata[FL_C] = q.c;
                  next_q.rdata[FL_Z] = q.z;
                  next_q.rdata[FL_N] = q.n;
               end
               A_STAT:  begin
                  next_q.rdata[ST_BUSY] = (q.fsm == ST_EXEC);
                  next_q.rdata[ST_ERR]  = q.err;
               end
               A_MEMP:  next_q.rdata[MEM_AW-1:0] = q.mp;
               A_MEMD:  next_q.rdata = {8'h00, q.mem[q.mp]};
               default: ;
            endcase
         end
      end

      ////////////////////////////////////////////////////////////////////
      unique case (q.fsm)
         ST_IDLE: if (cmd_valid) begin
            case (cmd.op)
               OP_JNB: begin
                  pn = q.pc + LEN_BIT;
                  tk = !q.r[cmd.rd][cmd.bit_sel];
                  cyc = tk ? CYC_BIT_T : CYC_BIT_NT;
                  if (tk) pn = br_f(pn, cmd.imm);
               end
               OP_JNZ, OP_JZ: begin
                  // Accumulator is only read here; flags are not touched
                  pn = q.pc + LEN_ACC;
                  tk = (q.acc != 8'h00) ^ (cmd.op == OP_JZ);
                  cyc = tk ? CYC_ACC_T : CYC_ACC_NT;
                  if (tk) pn = br_f(pn, cmd.imm);
               end
               OP_LEA: begin
                  off = cmd.off16 ? cmd.imm
                                  : {{8{cmd.imm[7]}}, cmd.imm[7:0]};
                  next_q.r[cmd.rd] = q.r[cmd.rs] + off;
                  pn = q.pc + (cmd.off16 ? LEN_LEA16 : LEN_LEA8);
                  cyc = CYC_LEA;
               end
               OP_LSR: begin
                  if (cmd.size == SZ_RSVD) begin
                     next_q.err = 1'b1;
                  end else begin
                     // Count register is read, never written
                     k = cmd.cnt_imm ? cmd.imm[CNT_W-1:0]
                                     : q.r[cmd.rs][CNT_W-1:0];
                     case (cmd.size)
                        SZ_DWORD: opnd = {q.r[rh], q.r[rl]};
                        SZ_WORD:  opnd = {16'h0000, q.r[cmd.rd]};
                        default:  opnd = {24'h000000, q.r[cmd.rd][7:0]};
                     endcase
                     sh = lsr_f(opnd, k, q.c);
                     case (cmd.size)
                        SZ_DWORD: begin
                           next_q.r[rl] = sh[15:0];
                           next_q.r[rh] = sh[31:16];
                           next_q.z = (sh[31:0] == '0);
                        end
                        SZ_WORD: begin
                           next_q.r[cmd.rd] = sh[15:0];
                           next_q.z = (sh[15:0] == '0);
                        end
                        default: begin
                           next_q.r[cmd.rd][7:0] = sh[7:0];
                           next_q.z = (sh[7:0] == '0);
                        end
                     endcase
                     if (k != '0) begin
                        next_q.c = sh[32];
                        next_q.n = 1'b0;
                     end
                     cyc = ((cmd.size == SZ_DWORD) ? CYC_SH32 : CYC_SH16)
                           + (k >> 1);
                     pn = q.pc + LEN_LSR;
                  end
               end
               OP_MOV: begin
                  if (cmd.size != SZ_BYTE && !wd) begin
                     next_q.err = 1'b1;
                  end else begin
                     rdm  = (cmd.mode == MV_RIND) || (cmd.mode == MV_ROFF)
                            || (cmd.mode == MV_RINC);
                     wrm  = (cmd.mode == MV_WIND) || (cmd.mode == MV_WOFF)
                            || (cmd.mode == MV_WINC);
                     offm = (cmd.mode == MV_ROFF) || (cmd.mode == MV_WOFF);
                     inc  = (cmd.mode == MV_RINC)
                            || (cmd.mode == MV_WINC);
                     pi   = wrm ? cmd.rd : cmd.rs;
                     ptr  = q.r[pi];
                     ea   = ptr + (offm ? {{8{cmd.imm[7]}}, cmd.imm[7:0]}
                                        : 16'h0000);
                     a    = ea[MEM_AW-1:0];
                     a1   = a + 1'b1;
                     if (rdm) begin
                        v = wd ? {q.mem[a1], q.mem[a]}
                               : {8'h00, q.mem[a]};
                     end else begin
                        v = wd ? q.r[cmd.rs] : {8'h00, q.r[cmd.rs][7:0]};
                     end
                     // Source is only read
                     if (wrm) begin
                        next_q.mem[a] = v[7:0];
                        if (wd) next_q.mem[a1] = v[15:8];
                     end else if (wd) begin
                        next_q.r[cmd.rd] = v;
                     end else begin
                        next_q.r[cmd.rd][7:0] = v[7:0];
                     end
                     if (inc) begin
                        next_q.r[pi] = ptr + (wd ? INC_WORD
                                                 : INC_BYTE);
                     end
                     next_q.n = wd ? v[15] : v[7];
                     next_q.z = wd ? (v == '0) : (v[7:0] == '0);
                     cyc = offm ? CYC_MOV_OFF
                                : (inc ? CYC_MOV_INC : CYC_MOV);
                     pn = q.pc + (offm ? LEN_MOV_OFF : LEN_MOV);
                  end
               end
               default: next_q.err = 1'b1;
            endcase
            next_q.pc  = pn;
            next_q.cnt = cyc - CYC_ONE;
            next_q.fsm = ST_EXEC;
         end
         ST_EXEC: begin
            if (q.cnt == '0) begin
               next_q.fsm  = ST_IDLE;
               next_q.done = 1'b1;
            end else begin
               next_q.cnt = q.cnt - 1'b1;
            end
         end
         default: next_q.fsm = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q     <= '0;
         q.fsm <= ST_IDLE;
      end else begin
         q <= next_q;
      end
   end

   assign rdata     = q.rdata;
   assign cmd_ready = (q.fsm == ST_IDLE);
   assign done      = q.done;
   assign fault     = q.err;

   ////////////////////////////////////////////////////////////////////////
   // Checks; h_q and h_c hold the state and command one cycle back
   bsm_st_t  h_q;
   bsm_cmd_t h_c;
   logic     go;

   always_ff @(posedge clk) begin
      h_q <= q;
      h_c <= cmd;
   end

   assign go = cmd_ready && cmd_valid && !bus.wr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence busy6_s;
      !cmd_ready [*6] ##1 cmd_ready;
   endsequence
   sequence busy3_s;
      !cmd_ready [*3] ##1 cmd_ready;
   endsequence
   sequence busy5_s;
      !cmd_ready [*5] ##1 cmd_ready;
   endsequence

   jnb_target_a: assert property (
      go && cmd.op == OP_JNB && !q.r[cmd.rd][cmd.bit_sel]
      |=> q.pc == br_f(h_q.pc + LEN_BIT, h_c.imm))
      else $error("bit-clear jump target wrong");

   jz_target_a: assert property (
      go && cmd.op == OP_JZ && q.acc == 8'h00
      |=> !q.pc[0] && q.pc == br_f(h_q.pc + LEN_ACC, h_c.imm))
      else $error("zero branch target wrong");

   jnz_target_a: assert property (
      go && cmd.op == OP_JNZ
      |=> q.pc == (h_q.acc != 8'h00 ? br_f(h_q.pc + LEN_ACC, h_c.imm)
                                    : h_q.pc + LEN_ACC))
      else $error("nonzero branch target wrong");

   acc_taken_a: assert property (
      go && (cmd.op == OP_JNZ || cmd.op == OP_JZ)
      && ((q.acc != 8'h00) ^ (cmd.op == OP_JZ)) |=> busy6_s)
      else $error("taken branch cost wrong");

   acc_fall_a: assert property (
      go && (cmd.op == OP_JNZ || cmd.op == OP_JZ)
      && !((q.acc != 8'h00) ^ (cmd.op == OP_JZ)) |=> busy3_s)
      else $error("untaken branch cost wrong");

   acc_kept_a: assert property (
      go && (cmd.op == OP_JNZ || cmd.op == OP_JZ)
      |=> q.acc == h_q.acc && {q.c, q.z, q.n} == {h_q.c, h_q.z, h_q.n})
      else $error("branch altered accumulator or flags");

   lea_sum_a: assert property (
      go && cmd.op == OP_LEA && !cmd.off16
      |=> q.r[h_c.rd] == h_q.r[h_c.rs] + {{8{h_c.imm[7]}}, h_c.imm[7:0]}
          && {q.c, q.z, q.n} == {h_q.c, h_q.z, h_q.n})
      else $error("effective address wrong");

   lsr_nclr_a: assert property (
      go && cmd.op == OP_LSR && cmd.size == SZ_WORD && cmd.cnt_imm
      && cmd.imm[CNT_W-1:0] != '0
      |=> !q.n && q.c == (|((h_q.r[h_c.rd] >> (h_c.imm[CNT_W-1:0] - 5'h01))
                            & 16'h0001)))
      else $error("shift flags wrong");

   lsr_zero_a: assert property (
      go && cmd.op == OP_LSR && cmd.size == SZ_WORD && cmd.cnt_imm
      && cmd.imm[CNT_W-1:0] == '0
      |=> q.r[h_c.rd] == h_q.r[h_c.rd] && q.n == h_q.n && q.c == h_q.c)
      else $error("zero count shift changed state");

   post_inc_a: assert property (
      go && cmd.op == OP_MOV && cmd.mode == MV_RINC
      && (cmd.size == SZ_WORD || cmd.size == SZ_BYTE) && cmd.rd != cmd.rs
      |=> q.r[h_c.rs] == h_q.r[h_c.rs]
          + ((h_c.size == SZ_WORD) ? INC_WORD : INC_BYTE))
      else $error("post increment step wrong");

   off_time_a: assert property (
      go && cmd.op == OP_MOV && cmd.mode == MV_ROFF
      && (cmd.size == SZ_BYTE || cmd.size == SZ_WORD) |=> busy5_s)
      else $error("offset move cost wrong");

endmodule

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
   import bsm_pkg::*;

   logic        clk             = 1'b0;
   logic        rst             = 1'b1;
   bsm_bus_t    bus             = '0;
   logic [15:0] rdata;
   logic        cmd_valid       = 1'b0;
   bsm_cmd_t    cmd             = '0;
   logic        cmd_ready;
   logic        done;
   logic        fault;
   int          fails           = 0;
   int          samples_checked = 0;

   always #20 clk = ~clk;

   bsm_exec u_dut (
      .clk       (clk),
      .rst       (rst),
      .bus       (bus),
      .rdata     (rdata),
      .cmd_valid (cmd_valid),
      .cmd       (cmd),
      .cmd_ready (cmd_ready),
      .done      (done),
      .fault     (fault)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so look then
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   function automatic bsm_cmd_t mk(bsm_op_t o, logic [1:0] s, logic [2:0] m,
                                   logic [2:0] d, logic [2:0] r, logic ci,
                                   logic o16, logic [3:0] bs,
                                   logic [15:0] im);
      mk = '{op: o, size: s, mode: m, rd: d, rs: r, cnt_imm: ci,
             off16: o16, bit_sel: bs, imm: im};
   endfunction

   // Counts cycles from the take edge to the done pulse
   task automatic exec(input bsm_cmd_t c, input int n);
      int k;
      @(posedge clk);
      cmd       <= c;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (done !== 1'b1 && k < 40);
      chk(32'(k), 32'(n));
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(A_PC, 16'h0000);
      rd(A_FLAGS, 16'h0000);
      rd(A_STAT, 16'h0000);
      wr(4'hE, 16'hFFFF);
      rd(4'hE, 16'h0000);
      // Accumulator branches, taken and not taken
      wr(A_PC, 16'h0100);
      wr(A_FLAGS, 16'h0007);
      exec(mk(OP_JZ, SZ_BYTE, 3'h0, 3'h0, 3'h0, 0, 0, 4'h0, 16'h00FF), 6);
      rd(A_PC, 16'h0100);
      rd(A_FLAGS, 16'h0007);
      wr(A_ACC, 16'h0005);
      exec(mk(OP_JZ, SZ_BYTE, 3'h0, 3'h0, 3'h0, 0, 0, 4'h0, 16'h0010), 3);
      rd(A_PC, 16'h0102);
      // Odd start shows the forced word alignment at the far reach
      wr(A_PC, 16'h0301);
      exec(mk(OP_JNZ, SZ_BYTE, 3'h0, 3'h0, 3'h0, 0, 0, 4'h0, 16'h007F), 6);
      rd(A_PC, 16'h0400);
      rd(A_ACC, 16'h0005);
      wr(A_ACC, 16'h0000);
      exec(mk(OP_JNZ, SZ_BYTE, 3'h0, 3'h0, 3'h0, 0, 0, 4'h0, 16'h007F), 3);
      rd(A_PC, 16'h0402);
      // Bit-clear jump, full backward reach
      wr(4'h1, 16'h0000);
      wr(A_PC, 16'h0200);
      exec(mk(OP_JNB, SZ_BYTE, 3'h0, 3'h1, 3'h0, 0, 0, 4'h3, 16'h0080), 10);
      rd(A_PC, 16'h0104);
      wr(4'h1, 16'h0008);
      exec(mk(OP_JNB, SZ_BYTE, 3'h0, 3'h1, 3'h0, 0, 0, 4'h3, 16'h0080), 6);
      rd(A_PC, 16'h0108);
      // Effective address, both offset widths
      wr(4'h2, 16'h1000);
      exec(mk(OP_LEA, SZ_WORD, 3'h0, 3'h3, 3'h2, 0, 0, 4'h0, 16'hFF80), 3);
      rd(4'h3, 16'h0F80);
      rd(4'h2, 16'h1000);
      exec(mk(OP_LEA, SZ_WORD, 3'h0, 3'h3, 3'h2, 0, 1, 4'h0, 16'h1234), 3);
      rd(4'h3, 16'h2234);
      rd(A_FLAGS, 16'h0007);
      // Logical right shift
      wr(4'h3, 16'h8001);
      exec(mk(OP_LSR, SZ_WORD, 3'h0, 3'h3, 3'h0, 1, 0, 4'h0, 16'h0001), 4);
      rd(4'h3, 16'h4000);
      rd(A_FLAGS, 16'h0001);
      wr(4'h4, 16'h0023);
      wr(4'h3, 16'h00F5);
      exec(mk(OP_LSR, SZ_WORD, 3'h0, 3'h3, 3'h4, 0, 0, 4'h0, 16'h0000), 5);
      rd(4'h3, 16'h001E);
      rd(4'h4, 16'h0023);
      rd(A_FLAGS, 16'h0001);
      wr(A_FLAGS, 16'h0005);
      exec(mk(OP_LSR, SZ_WORD, 3'h0, 3'h3, 3'h0, 1, 0, 4'h0, 16'h0000), 4);
      rd(4'h3, 16'h001E);
      rd(A_FLAGS, 16'h0005);
      wr(4'h5, 16'h12F0);
      exec(mk(OP_LSR, SZ_BYTE, 3'h0, 3'h5, 3'h0, 1, 0, 4'h0, 16'h0004), 6);
      rd(4'h5, 16'h120F);
      rd(A_FLAGS, 16'h0000);
      wr(4'h3, 16'h8000);
      exec(mk(OP_LSR, SZ_WORD, 3'h0, 3'h3, 3'h0, 1, 0, 4'h0, 16'h001F), 19);
      rd(4'h3, 16'h0000);
      rd(A_FLAGS, 16'h0002);
      wr(4'h6, 16'h8001);
      wr(4'h7, 16'h8000);
      exec(mk(OP_LSR, SZ_DWORD, 3'h0, 3'h7, 3'h0, 1, 0, 4'h0, 16'h0010), 14);
      rd(4'h6, 16'h8000);
      rd(4'h7, 16'h0000);
      rd(A_FLAGS, 16'h0001);
      // Reserved size code is refused and latched
      wr(A_PC, 16'h0500);
      exec(mk(OP_LSR, SZ_RSVD, 3'h0, 3'h3, 3'h0, 1, 0, 4'h0, 16'h0001), 1);
      chk(fault, 1'b1);
      rd(A_PC, 16'h0500);
      rd(A_STAT, 16'h0002);
      wr(A_STAT, 16'h0002);
      rd(A_STAT, 16'h0000);
      // Data moves through memory and between registers
      wr(4'h0, 16'h0010);
      wr(4'h1, 16'hBEEF);
      exec(mk(OP_MOV, SZ_WORD, MV_WIND, 3'h0, 3'h1, 0, 0, 4'h0, 16'h0000), 3);
      wr(A_MEMP, 16'h0010);
      rd(A_MEMD, 16'h00EF);
      wr(A_MEMP, 16'h0011);
      rd(A_MEMD, 16'h00BE);
      rd(4'h1, 16'hBEEF);
      exec(mk(OP_MOV, SZ_BYTE, MV_RINC, 3'h2, 3'h0, 0, 0, 4'h0, 16'h0000), 4);
      rd(4'h2, 16'h10EF);
      rd(4'h0, 16'h0011);
      exec(mk(OP_MOV, SZ_WORD, MV_ROFF, 3'h3, 3'h0, 0, 0, 4'h0, 16'h00FF), 5);
      rd(4'h3, 16'hBEEF);
      rd(4'h0, 16'h0011);
      exec(mk(OP_MOV, SZ_WORD, MV_WINC, 3'h0, 3'h2, 0, 0, 4'h0, 16'h0000), 4);
      rd(4'h0, 16'h0013);
      wr(A_MEMP, 16'h0012);
      rd(A_MEMD, 16'h0010);
      exec(mk(OP_MOV, SZ_WORD, MV_RR, 3'h4, 3'h3, 0, 0, 4'h0, 16'h0000), 3);
      rd(4'h4, 16'hBEEF);
      exec(mk(OP_MOV, SZ_DWORD, MV_RR, 3'h4, 3'h3, 0, 0, 4'h0, 16'h0000), 1);
      rd(A_STAT, 16'h0002);
      end_of_test();
   end

endmodule

`default_nettype wire
